/* File: shared/esc_match_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface esc_match_if;
   import esc_pkg::*;
   logic cfg_we;
   logic [7:0] cfg_addr;
   logic [7:0] cfg_wdata;
   logic [7:0] cfg_rdata;
   logic [7:0] hdr_len;
   logic [7:0] act_len;
   logic [7:0] deact_len;
   logic [7:0] term;
   logic rx_valid;
   logic [7:0] rx_data;
   logic act_hit;
   logic deact_hit;
   modport ctl(output cfg_we, cfg_addr, cfg_wdata, hdr_len, act_len,
      deact_len, term, rx_valid, rx_data,
      input cfg_rdata, act_hit, deact_hit);
   modport mat(input cfg_we, cfg_addr, cfg_wdata, hdr_len, act_len,
      deact_len, term, rx_valid, rx_data,
      output cfg_rdata, act_hit, deact_hit);
endinterface
`default_nettype wire

/* File: shared/esc_pkg.sv */
package esc_pkg;
   // Timing: one second is the base of every timeout
   localparam int CLK_MHZ = 250;
   localparam int SEC_US = 1000000;
   localparam int SEC_CYC = CLK_MHZ * SEC_US;
   localparam logic [16:0] MIN_SEC = 17'h0003c;
   localparam int DIV_W = 28;
   localparam int SEC_W = 16;
   localparam int DIN_NUM = 8;

   // Serial command storage
   localparam int HDR_MAX = 128;
   localparam int STR_MAX = 32;
   localparam int MEM_DEPTH = HDR_MAX + 2 * STR_MAX;
   localparam logic [7:0] ACT_BASE = 8'h80;
   localparam logic [7:0] DCT_BASE = 8'ha0;
   localparam logic [7:0] CHAR_TOP = 8'h7e;

   // Register map, byte offsets inside each region
   localparam logic [1:0] RGN_GLOB = 2'h0;
   localparam logic [1:0] RGN_MAIN = 2'h1;
   localparam logic [1:0] RGN_AUX = 2'h2;
   localparam logic [9:0] OFF_CTRL = 10'h000;
   localparam logic [9:0] OFF_ACT_TMO = 10'h004;
   localparam logic [9:0] OFF_DCT_TMO = 10'h008;
   localparam logic [9:0] OFF_STATUS = 10'h00c;
   localparam logic [9:0] OFF_HDR_LEN = 10'h300;
   localparam logic [9:0] OFF_ACT_LEN = 10'h304;
   localparam logic [9:0] OFF_DCT_LEN = 10'h308;
   localparam logic [9:0] OFF_TERM = 10'h30c;

   // Reset values
   localparam logic [7:0] ACT_MIN_RST = 8'h0a;
   localparam logic [15:0] DCT_SEC_RST = 16'h0005;

   typedef enum logic [1:0] {
      ROLE_NONE = 2'b00,
      ROLE_DEACT = 2'b01,
      ROLE_ACT = 2'b10,
      ROLE_BOTH = 2'b11
   } esc_role_e;

   typedef enum logic [1:0] {
      M_HDR = 2'b00,
      M_STR = 2'b01
   } esc_mstate_e;

   // Role decoding shared by every source
   function automatic logic esc_has_act(input logic [1:0] r);
      return r[1];
   endfunction

   function automatic logic esc_has_deact(input logic [1:0] r);
      return r[0];
   endfunction
endpackage

/* File: tb/esc_far.sv */
`timescale 1ns/10ps
`default_nettype none
module esc_far (
   input wire logic clk_sys, // System clock
   output logic enc_in, // Encoder level
   output logic [7:0] din, // Digital inputs
   output logic main_rx_valid, // Main byte strobe
   output logic [7:0] main_rx_data, // Main byte
   output logic aux_rx_valid, // Aux byte strobe
   output logic [7:0] aux_rx_data // Aux byte
);
   logic enc_run;
   logic [1:0] enc_div;
   // Idle state: encoder still, inputs low, data lines scrambled
   initial begin
      enc_run = 1'b0;
      enc_div = 2'h0;
      enc_in = 1'b0;
      din = 8'h00;
      main_rx_valid = 1'b0;
      aux_rx_valid = 1'b0;
      main_rx_data = 8'h5a;
      aux_rx_data = 8'ha5;
   end
   // A stopped encoder simply holds its last level
   always @(posedge clk_sys) begin
      enc_div <= enc_div + 2'h1;
      if (enc_run && enc_div == 2'h0) begin
         enc_in <= ~enc_in;
      end
   end
   // One byte per strobe; data inverted after so a stale byte never repeats
   task automatic send(input bit aux, input logic [7:0] b);
      @(posedge clk_sys);
      if (aux) begin
         aux_rx_valid <= 1'b1;
         aux_rx_data <= b;
      end else begin
         main_rx_valid <= 1'b1;
         main_rx_data <= b;
      end
      @(posedge clk_sys);
      aux_rx_valid <= 1'b0;
      main_rx_valid <= 1'b0;
      aux_rx_data <= ~aux_rx_data;
      main_rx_data <= ~main_rx_data;
   endtask
endmodule
`default_nettype wire

/* File: tb/esc_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module esc_props (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Async reset
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic saving, // Saving active
   input wire logic scan_on // Scanners on
);
   import esc_pkg::*;
   logic wr_acc;
   logic port_rgn;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Qualifiers for answered writes into a serial port region
   assign wr_acc = psel && penable && pwrite && pready;
   assign port_rgn = paddr[11:10] == RGN_MAIN || paddr[11:10] == RGN_AUX;

   scan_inv_a: assert property (scan_on != saving)
      else $error("scan_on equals saving");
   ready_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_only_a: assert property (pready |-> psel && penable
      && $past(psel && !penable)) else $error("ready outside access");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   term_range_a: assert property (wr_acc && port_rgn
      && paddr[9:0] == OFF_TERM && pwdata[7:0] > CHAR_TOP |-> pslverr)
      else $error("terminator above range taken");
   hdr_char_a: assert property (wr_acc && port_rgn
      && paddr[9:2] < 8'h80 && pwdata[7:0] > CHAR_TOP |-> pslverr)
      else $error("header byte above range taken");
   hdr_len_a: assert property (wr_acc && port_rgn
      && paddr[9:0] == OFF_HDR_LEN && pwdata > 32'h80 |-> pslverr)
      else $error("header length above limit taken");
   unmapped_a: assert property (psel && penable && paddr[11:10] == 2'h3
      |-> pslverr) else $error("unmapped access not refused");
   status_a: assert property (pready && !pwrite && paddr == 12'h00c
      && $stable(saving) |-> prdata[1:0] == {scan_on, saving})
      else $error("status does not show saving");

   cover property ($rose(saving));
   cover property ($fell(saving));
   cover property (pslverr);
endmodule

bind esc_top esc_props u_props (.clk_sys, .reset, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .saving,
   .scan_on);
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
   total_checks++; \
   if ((got) !== (ex)) begin \
      n_fail++; \
      $display("mismatch %s expected %h seen %h", nm, ex, got); \
   end
module tb;
   import esc_pkg::*;
   typedef struct {
      logic err;
      logic [31:0] data;
      logic [31:0] mask;
      string nm;
   } esc_note_s;
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_val;
   logic enc_in, main_rx_valid, aux_rx_valid, saving, scan_on;
   logic [7:0] din, main_rx_data, aux_rx_data;
   int n_fail = 0;
   int total_checks = 0;
   esc_note_s notes[$];
   esc_note_s cur;

   esc_top #(.SEC_CYCLES(20)) u_dut (.clk_sys, .reset, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enc_in, .din,
      .main_rx_valid, .main_rx_data, .aux_rx_valid, .aux_rx_data,
      .saving, .scan_on);
   esc_far u_far (.clk_sys, .enc_in, .din, .main_rx_valid, .main_rx_data,
      .aux_rx_valid, .aux_rx_data);

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Each answered transfer retires the oldest note; sampled mid-cycle
   always @(negedge clk_sys) begin
      if (pready === 1'b1 && notes.size() > 0) begin
         cur = notes.pop_front();
         `CHK(cur.nm, cur.err, pslverr)
         `CHK(cur.nm, cur.data & cur.mask, prdata & cur.mask)
      end
   end

   // Hold the request until ready is seen; no fixed latency assumed
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic e, input logic [31:0] x,
         input logic [31:0] m);
      int k;
      notes.push_back('{e, x, m, $sformatf("reg %h", a)});
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         report_and_stop();
      end
      rd_val = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic e);
      apb(1'b1, a, d, e, 32'h0, 32'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x,
         input logic e);
      apb(1'b0, a, 32'h0, e, x, 32'hffffffff);
   endtask

   task automatic chk_state(input logic e);
      apb(1'b0, 12'h00c, 32'h0, 1'b0, {30'h0, ~e, e}, 32'h3);
   endtask

   // Poll saving under a bound, then record the settled state
   task automatic wait_saving(input logic e);
      int k;
      k = 0;
      apb(1'b0, 12'h00c, 32'h0, 1'b0, 32'h0, 32'h0);
      while (rd_val[0] !== e && k < 100) begin
         apb(1'b0, 12'h00c, 32'h0, 1'b0, 32'h0, 32'h0);
         k++;
      end
      if (k == 100) begin
         n_fail++;
         report_and_stop();
      end
      chk_state(e);
   endtask

   task automatic set_din(input int i, input logic v);
      @(posedge clk_sys);
      u_far.din[i] <= v;
      repeat (8) @(posedge clk_sys);
   endtask

   // Header 'A', activate "ON", deactivate "OF"
   task automatic setup_port(input logic [11:0] b, input logic [7:0] t);
      wr(b, 32'h41, 1'b0);
      wr(b + 12'h200, 32'h4f, 1'b0);
      wr(b + 12'h204, 32'h4e, 1'b0);
      wr(b + 12'h280, 32'h4f, 1'b0);
      wr(b + 12'h284, 32'h46, 1'b0);
      wr(b + 12'h300, 32'h1, 1'b0);
      wr(b + 12'h304, 32'h2, 1'b0);
      wr(b + 12'h308, 32'h2, 1'b0);
      wr(b + 12'h30c, {24'h0, t}, 1'b0);
   endtask

   task automatic cmd(input bit aux, input logic [7:0] s0, s1, t);
      u_far.send(aux, 8'h41);
      u_far.send(aux, s0);
      u_far.send(aux, s1);
      u_far.send(aux, t);
      repeat (3) @(posedge clk_sys);
   endtask

   initial begin
      repeat (90000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end

   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      void'($urandom(32'h8fb7));
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      rd(12'h000, 32'h0, 1'b0);
      rd(12'h004, {24'h0, ACT_MIN_RST}, 1'b0);
      rd(12'h008, {16'h0, DCT_SEC_RST}, 1'b0);
      chk_state(1'b0);
      rd(12'hc00, 32'h0, 1'b1);
      $display("test reset done");
      wr(12'h70c, 32'h7f, 1'b1);
      rd(12'h70c, 32'h0, 1'b0);
      wr(12'h400, 32'h80, 1'b1);
      wr(12'h700, 32'h81, 1'b1);
      wr(12'h700, 32'h80, 1'b0);
      rd(12'h700, 32'h80, 1'b0);
      wr(12'h704, 32'h21, 1'b1);
      wr(12'h00c, 32'h3, 1'b0);
      chk_state(1'b0);
      $display("test refusals done");
      setup_port(12'h400, 8'h0d);
      setup_port(12'h800, 8'h7e);
      // Every main role; aux (both roles) clears afterwards
      for (int r = 0; r < 4; r++) begin
         wr(12'h000, {24'h0, 2'h3, r[1:0], 4'h0}, 1'b0);
         repeat (4) u_far.send(1'b0, 8'($urandom | 32'h80));
         cmd(1'b0, 8'h4f, 8'h4e, 8'h0d);
         chk_state(r[1]);
         cmd(1'b0, 8'h4f, 8'h46, 8'h0d);
         chk_state(1'(r[1] & ~r[0]));
         cmd(1'b1, 8'h4f, 8'h46, 8'h7e);
         chk_state(1'b0);
      end
      cmd(1'b1, 8'h4f, 8'h4e, 8'h0d);
      chk_state(1'b0);
      u_far.send(1'b0, 8'h41);
      cmd(1'b0, 8'h4f, 8'h4e, 8'h0d);
      chk_state(1'b0);
      $display("test serial done");
      wr(12'h000, 32'h0d0c, 1'b0);
      set_din(5, 1'b1);
      chk_state(1'b1);
      set_din(5, 1'b0);
      chk_state(1'b0);
      set_din(2, 1'b1);
      chk_state(1'b0);
      wr(12'h000, 32'h050c, 1'b0);
      set_din(5, 1'b1);
      chk_state(1'b1);
      set_din(5, 1'b0);
      chk_state(1'b1);
      set_din(5, 1'b1);
      chk_state(1'b0);
      $display("test digital input done");
      wr(12'h004, 32'h0, 1'b0);
      wr(12'h008, 32'h2, 1'b0);
      wr(12'h000, 32'h3, 1'b0);
      wait_saving(1'b1);
      @(posedge clk_sys);
      u_far.enc_run <= 1'b1;
      wait_saving(1'b0);
      wr(12'h000, 32'h1, 1'b0);
      @(posedge clk_sys);
      u_far.enc_run <= 1'b0;
      repeat (200) @(posedge clk_sys);
      chk_state(1'b0);
      wr(12'h000, 32'h0, 1'b0);
      @(posedge clk_sys);
      u_far.enc_run <= 1'b0;
      repeat (100) @(posedge clk_sys);
      chk_state(1'b0);
      $display("test encoder done");
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: verilog/esc_matcher.sv */
`timescale 1ns/10ps
`default_nettype none
module esc_matcher (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Async reset, active high
   esc_match_if.mat mi // Config, byte stream and hits
);
   import esc_pkg::*;

   logic [7:0] mem [MEM_DEPTH];
   esc_mstate_e state;
   logic [7:0] idx;
   logic a_ok;
   logic d_ok;
   logic h_ok;
   logic a_done;
   logic d_done;
   logic a_cont;
   logic d_cont;
   logic [7:0] hdr_b;
   logic [7:0] act_b;
   logic [7:0] dct_b;

   // Header, activation and deactivation bytes share one array
   always_ff @(posedge clk_sys) begin
      if (mi.cfg_we) begin
         mem[mi.cfg_addr] <= mi.cfg_wdata;
      end
   end
   assign mi.cfg_rdata = mem[mi.cfg_addr];

   assign hdr_b = mem[idx];
   assign act_b = mem[ACT_BASE + idx];
   assign dct_b = mem[DCT_BASE + idx];

   // Both strings are tracked at once; terminator closes either
   assign h_ok = mi.rx_data == hdr_b;
   assign a_done = a_ok && idx == mi.act_len && mi.rx_data == mi.term;
   assign d_done = d_ok && idx == mi.deact_len && mi.rx_data == mi.term;
   assign a_cont = a_ok && idx < mi.act_len && mi.rx_data == act_b;
   assign d_cont = d_ok && idx < mi.deact_len && mi.rx_data == dct_b;

   // Sequence tracker: header, then string, then terminator
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= M_HDR;
         idx <= 8'h00;
         a_ok <= 1'b0;
         d_ok <= 1'b0;
      end else if (state == M_HDR && mi.hdr_len == 8'h00) begin
         state <= M_STR;
         idx <= 8'h00;
         a_ok <= mi.act_len != 8'h00;
         d_ok <= mi.deact_len != 8'h00;
      end else if (mi.rx_valid) begin
         case (state)
            M_HDR: begin
               if (h_ok && idx + 8'h01 == mi.hdr_len) begin
                  state <= M_STR;
                  idx <= 8'h00;
                  a_ok <= mi.act_len != 8'h00;
                  d_ok <= mi.deact_len != 8'h00;
               end else if (h_ok) begin
                  idx <= idx + 8'h01;
               end else begin
                  idx <= 8'h00;
               end
            end
            M_STR: begin
               if (!(a_done || d_done) && (a_cont || d_cont)) begin
                  idx <= idx + 8'h01;
                  a_ok <= a_cont;
                  d_ok <= d_cont;
               end else begin
                  state <= M_HDR;
                  idx <= 8'h00;
                  a_ok <= 1'b0;
                  d_ok <= 1'b0;
               end
            end
            default: begin
               state <= M_HDR;
               idx <= 8'h00;
               a_ok <= 1'b0;
               d_ok <= 1'b0;
            end
         endcase
      end
   end

   // One-cycle hit pulses, only on a complete framed command
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mi.act_hit <= 1'b0;
         mi.deact_hit <= 1'b0;
      end else begin
         mi.act_hit <= mi.rx_valid && state == M_STR && a_done;
         mi.deact_hit <= mi.rx_valid && state == M_STR && d_done;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/esc_top.sv */
// Operation
// - Encoder role selectable: none, deactivate, activate, or both.
// - A source with no role never changes the saving state.
// - Deactivating source firing leaves saving; motors and lasers go on.
// - Activating source firing enters saving; motors and lasers go off.
// - Combined role can both enter and leave saving.
// - Encoder silent longer than the minute timeout enters saving.
// - Encoder running for the second timeout leaves saving.
// - Activation timeout only matters while encoder role includes activation.
// - Digital input role selectable with the same four choices.
// - A selector picks which digital input controls saving.
// - Selected input is read by edge or by level, as configured.
// - Main serial port role selectable with the same four choices.
// - Aux serial port is an independent source with own framing.
// - Each command starts with a configured header up to 128 bytes.
// - Each command ends with a configured one-byte terminator.
// - Header and terminator bytes above 7Eh are refused.
// - Activation string acts only on ports whose role includes activation.
// - Deactivation string acts only on ports whose role includes deactivation.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module esc_top #(
   parameter int unsigned SEC_CYCLES = esc_pkg::SEC_CYC
) (
   input wire logic clk_sys, // System clock, 250 MHz
   input wire logic reset, // Async reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic enc_in, // Encoder pulse level
   input wire logic [esc_pkg::DIN_NUM-1:0] din, // Digital inputs
   input wire logic main_rx_valid, // Main port byte strobe
   input wire logic [7:0] main_rx_data, // Main port byte
   input wire logic aux_rx_valid, // Aux port byte strobe
   input wire logic [7:0] aux_rx_data, // Aux port byte
   output logic saving, // Energy saving active
   output logic scan_on // Motors and lasers enabled
);
   import esc_pkg::*;

   logic [1:0] enc_role;
   logic [1:0] din_role;
   logic [1:0] ser_role [2];
   logic [2:0] din_sel;
   logic din_level;
   logic [7:0] act_min;
   logic [15:0] dct_sec;
   logic [7:0] hdr_len [2];
   logic [7:0] act_len [2];
   logic [7:0] dct_len [2];
   logic [7:0] term [2];
   logic [7:0] cfg_rd [2];
   logic ser_act [2];
   logic ser_dct [2];
   logic [1:0] rgn;
   logic pidx;
   logic is_port;
   logic mem_hit;
   logic acc_ok;
   logic [31:0] next_rdata;
   logic next_err;
   logic [DIV_W-1:0] div_cnt;
   logic tick;
   logic enc_q;
   logic enc_seen;
   logic moved;
   logic [SEC_W-1:0] stop_sec;
   logic [SEC_W-1:0] run_sec;
   logic [16:0] act_lim;
   logic enc_act;
   logic enc_dct;
   logic [DIN_NUM-1:0] din_s1;
   logic [DIN_NUM-1:0] din_s2;
   logic din_now;
   logic din_q;
   logic din_rise;
   logic din_act;
   logic din_dct;
   logic act_any;
   logic dct_any;

   esc_match_if pif[2] ();

   // Address split: region, port index, string memory window
   assign rgn = paddr[11:10];
   assign pidx = rgn == RGN_AUX;
   assign is_port = rgn == RGN_MAIN || rgn == RGN_AUX;
   assign mem_hit = paddr[9:2] < 8'(MEM_DEPTH);
   assign acc_ok = psel && penable && pready && !pslverr;

   // Read mux and refusal check, stable from the setup cycle on
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (rgn == RGN_GLOB) begin
         case (paddr[9:0])
            OFF_CTRL: next_rdata = {20'h00000, din_level, din_sel,
               ser_role[1], ser_role[0], din_role, enc_role};
            OFF_ACT_TMO: next_rdata = {24'h000000, act_min};
            OFF_DCT_TMO: next_rdata = {16'h0000, dct_sec};
            OFF_STATUS: next_rdata = {28'h0000000, din_now, moved,
               scan_on, saving};
            default: next_err = 1'b1;
         endcase
      end else if (is_port && mem_hit) begin
         next_rdata = {24'h000000, cfg_rd[pidx]};
         // Header bytes must stay printable-or-control, not above 7Eh
         if (pwrite && paddr[9:2] < ACT_BASE &&
             pwdata[7:0] > CHAR_TOP) begin
            next_err = 1'b1;
         end
      end else if (is_port) begin
         case (paddr[9:0])
            OFF_HDR_LEN: begin
               next_rdata = {24'h000000, hdr_len[pidx]};
               next_err = pwrite && pwdata > 32'(HDR_MAX);
            end
            OFF_ACT_LEN: begin
               next_rdata = {24'h000000, act_len[pidx]};
               next_err = pwrite && pwdata > 32'(STR_MAX);
            end
            OFF_DCT_LEN: begin
               next_rdata = {24'h000000, dct_len[pidx]};
               next_err = pwrite && pwdata > 32'(STR_MAX);
            end
            OFF_TERM: begin
               next_rdata = {24'h000000, term[pidx]};
               next_err = pwrite && pwdata > {24'h000000, CHAR_TOP};
            end
            default: next_err = 1'b1;
         endcase
      end else begin
         next_err = 1'b1;
      end
   end

   // Fixed one access cycle; answer registered so outputs are flops
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && next_err;
         prdata <= (psel && !penable && !pwrite) ? next_rdata :
            32'h0000_0000;
      end
   end

   // Global configuration
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         enc_role <= ROLE_NONE;
         din_role <= ROLE_NONE;
         ser_role[0] <= ROLE_NONE;
         ser_role[1] <= ROLE_NONE;
         din_sel <= 3'h0;
         din_level <= 1'b0;
         act_min <= ACT_MIN_RST;
         dct_sec <= DCT_SEC_RST;
      end else if (acc_ok && pwrite && rgn == RGN_GLOB) begin
         case (paddr[9:0])
            OFF_CTRL: begin
               enc_role <= pwdata[1:0];
               din_role <= pwdata[3:2];
               ser_role[0] <= pwdata[5:4];
               ser_role[1] <= pwdata[7:6];
               din_sel <= pwdata[10:8];
               din_level <= pwdata[11];
            end
            OFF_ACT_TMO: act_min <= pwdata[7:0];
            OFF_DCT_TMO: dct_sec <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Per-port framing configuration
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int p = 0; p < 2; p++) begin
            hdr_len[p] <= 8'h00;
            act_len[p] <= 8'h00;
            dct_len[p] <= 8'h00;
            term[p] <= 8'h00;
         end
      end else if (acc_ok && pwrite && is_port && !mem_hit) begin
         case (paddr[9:0])
            OFF_HDR_LEN: hdr_len[pidx] <= pwdata[7:0];
            OFF_ACT_LEN: act_len[pidx] <= pwdata[7:0];
            OFF_DCT_LEN: dct_len[pidx] <= pwdata[7:0];
            OFF_TERM: term[pidx] <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Two matchers, one per serial port, each with its own strings
   generate
      for (genvar g = 0; g < 2; g++) begin : g_port
         assign pif[g].cfg_we = acc_ok && pwrite && is_port && mem_hit &&
            pidx == 1'(g);
         assign pif[g].cfg_addr = paddr[9:2];
         assign pif[g].cfg_wdata = pwdata[7:0];
         assign pif[g].hdr_len = hdr_len[g];
         assign pif[g].act_len = act_len[g];
         assign pif[g].deact_len = dct_len[g];
         assign pif[g].term = term[g];
         assign pif[g].rx_valid = (g == 0) ? main_rx_valid : aux_rx_valid;
         assign pif[g].rx_data = (g == 0) ? main_rx_data : aux_rx_data;
         assign cfg_rd[g] = pif[g].cfg_rdata;
         // A string counts only if the port role allows it
         assign ser_act[g] = pif[g].act_hit &&
            esc_has_act(ser_role[g]);
         assign ser_dct[g] = pif[g].deact_hit &&
            esc_has_deact(ser_role[g]);
         esc_matcher u_match (
            .clk_sys(clk_sys),
            .reset(reset),
            .mi(pif[g])
         );
      end
   endgenerate

   // One-second enable; coarse on purpose, timeouts are seconds apart
   assign tick = div_cnt == DIV_W'(SEC_CYCLES - 1);
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         div_cnt <= '0;
      end else if (tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // Encoder movement seen in the current second; edge beats clear
   assign moved = enc_seen || (enc_in != enc_q);
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         enc_q <= 1'b0;
         enc_seen <= 1'b0;
      end else begin
         enc_q <= enc_in;
         enc_seen <= (enc_in != enc_q) || (enc_seen && !tick);
      end
   end

   // Silent and running second counters, saturating
   assign act_lim = 17'(act_min) * MIN_SEC;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         stop_sec <= '0;
         run_sec <= '0;
      end else if (tick) begin
         if (moved) begin
            stop_sec <= '0;
            run_sec <= (&run_sec) ? run_sec : run_sec + 1'b1;
         end else begin
            run_sec <= '0;
            stop_sec <= (&stop_sec) ? stop_sec : stop_sec + 1'b1;
         end
      end
   end

   // Encoder events; a role without activation ignores its timeout
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         enc_act <= 1'b0;
         enc_dct <= 1'b0;
      end else begin
         enc_act <= tick && !moved && esc_has_act(enc_role) &&
            17'(stop_sec) >= act_lim;
         enc_dct <= tick && moved && esc_has_deact(enc_role) &&
            run_sec + 1'b1 == dct_sec;
      end
   end

   // Synchronise all inputs so a reselect sees a settled level
   generate
      for (genvar b = 0; b < DIN_NUM; b++) begin : g_sync
         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               din_s1[b] <= 1'b0;
               din_s2[b] <= 1'b0;
            end else begin
               din_s1[b] <= din[b];
               din_s2[b] <= din_s1[b];
            end
         end
      end
   endgenerate

   assign din_now = din_s2[din_sel];
   assign din_rise = din_now && !din_q;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         din_q <= 1'b0;
      end else begin
         din_q <= din_now;
      end
   end

   // Level: high asks saving, low asks run; edge: rise fires, both toggles
   always_comb begin
      if (din_level) begin
         din_act = esc_has_act(din_role) && din_now;
         din_dct = esc_has_deact(din_role) && !din_now;
      end else begin
         din_act = esc_has_act(din_role) && din_rise &&
            (din_role != ROLE_BOTH || !saving);
         din_dct = esc_has_deact(din_role) && din_rise &&
            (din_role != ROLE_BOTH || saving);
      end
   end

   assign act_any = enc_act || din_act || ser_act[0] || ser_act[1];
   assign dct_any = enc_dct || din_dct || ser_dct[0] || ser_dct[1];

   // Saving state; leaving wins so scanners never stay off by a race
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         saving <= 1'b0;
         scan_on <= 1'b1;
      end else if (dct_any) begin
         saving <= 1'b0;
         scan_on <= 1'b1;
      end else if (act_any) begin
         saving <= 1'b1;
         scan_on <= 1'b0;
      end
   end
endmodule
`default_nettype wire
